// ==== exg_gpio_top.sv ====
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
// Operation
// - A one written to bits 2:0 of the first register clears the data bit of bidir pins 6..4.
// - A one written to bits 5:3 of the first register sets the data bit of bidir pins 6..4.
// - A one written to bits 8:6 of the first register clears the enable of bidir pins 6..4.
// - A one written to bits 11:9 of the first register sets the enable of bidir pins 6..4.
// - Bits 14:12 of the first register read the synchronised levels of bidir pins 6..4.
// - A one written to bits 3:0 of the second register clears the data of output pins 3..0.
// - A one written to bits 7:4 of the second register sets the data of output pins 3..0.
// - A one written to bits 11:8 of the second register clears the enable of output pins.
// - A one written to bits 15:12 of the second register sets the enable of output pins.
// - Bits 19:16 of the second register read the synchronised levels of input pins 3..0.
module exg_gpio_top (
	input  wire logic                     i_clk,
	input  wire logic                     i_sys_rst,
	input  wire logic [exg_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [exg_pkg::DATA_W-1:0] i_wdata,
	input  wire logic                     i_wr,
	input  wire logic                     i_rd,
	output logic      [exg_pkg::DATA_W-1:0] o_rdata,
	input  wire logic [2:0]               i_bpin,
	output logic      [2:0]               o_bpin,
	output logic      [2:0]               o_bpin_oe_n,
	output logic      [3:0]               o_opin,
	output logic      [3:0]               o_opin_oe_n,
	input  wire logic [3:0]               i_ipin
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [2:0]  bin_meta;
		logic [2:0]  bin_sync;
		logic [3:0]  iin_meta;
		logic [3:0]  iin_sync;
		logic [31:0] rdata;
		logic [2:0]  bout;
		logic [2:0]  boe_n;
		logic [3:0]  oout;
		logic [3:0]  ooe_n;
	} exg_top_state_type;

	exg_top_state_type st_r;
	exg_top_state_type st_nxt;

	// ****************************************************************
	// Control vector banks
	// ****************************************************************
	exg_sc_if #(.W(exg_pkg::BIDIR_N)) bdat_if ();
	exg_sc_if #(.W(exg_pkg::BIDIR_N)) ben_if  ();
	exg_sc_if #(.W(exg_pkg::XTRA_N))  odat_if ();
	exg_sc_if #(.W(exg_pkg::XTRA_N))  oen_if  ();

	exg_sc_bank #(.W(exg_pkg::BIDIR_N), .RST(exg_pkg::BIDIR_RST)) u_bdat (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.sc        (bdat_if.bank)
	);

	exg_sc_bank #(.W(exg_pkg::BIDIR_N), .RST(exg_pkg::BIDIR_RST)) u_ben (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.sc        (ben_if.bank)
	);

	exg_sc_bank #(.W(exg_pkg::XTRA_N), .RST(exg_pkg::XTRA_RST)) u_odat (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.sc        (odat_if.bank)
	);

	exg_sc_bank #(.W(exg_pkg::XTRA_N), .RST(exg_pkg::XTRA_RST)) u_oen (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.sc        (oen_if.bank)
	);

	// ****************************************************************
	// Write decode
	// ****************************************************************
	logic wr_bidir;
	logic wr_xtra;

	// Register hit on a write strobe
	assign wr_bidir = i_wr && (i_addr == exg_pkg::BIDIR_OFS);
	assign wr_xtra  = i_wr && (i_addr == exg_pkg::XTRA_OFS);

	assign bdat_if.clr_mask = wr_bidir ? i_wdata[exg_pkg::B_DCLR_LSB +: exg_pkg::BIDIR_N] : '0;
	assign bdat_if.set_mask = wr_bidir ? i_wdata[exg_pkg::B_DSET_LSB +: exg_pkg::BIDIR_N] : '0;
	assign ben_if.clr_mask  = wr_bidir ? i_wdata[exg_pkg::B_ECLR_LSB +: exg_pkg::BIDIR_N] : '0;
	assign ben_if.set_mask  = wr_bidir ? i_wdata[exg_pkg::B_ESET_LSB +: exg_pkg::BIDIR_N] : '0;
	assign odat_if.clr_mask = wr_xtra ? i_wdata[exg_pkg::X_DCLR_LSB +: exg_pkg::XTRA_N] : '0;
	assign odat_if.set_mask = wr_xtra ? i_wdata[exg_pkg::X_DSET_LSB +: exg_pkg::XTRA_N] : '0;
	assign oen_if.clr_mask  = wr_xtra ? i_wdata[exg_pkg::X_ECLR_LSB +: exg_pkg::XTRA_N] : '0;
	assign oen_if.set_mask  = wr_xtra ? i_wdata[exg_pkg::X_ESET_LSB +: exg_pkg::XTRA_N] : '0;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		st_nxt = st_r;
		// Two-stage synchronisers for pin levels
		st_nxt.bin_meta = i_bpin;
		st_nxt.bin_sync = st_r.bin_meta;
		st_nxt.iin_meta = i_ipin;
		st_nxt.iin_sync = st_r.iin_meta;
		st_nxt.bout  = bdat_if.value & ben_if.value;
		st_nxt.boe_n = ~ben_if.value;
		st_nxt.oout  = odat_if.value & oen_if.value;
		st_nxt.ooe_n = ~oen_if.value;
		// unread and reserved bits stay zero
		st_nxt.rdata = exg_pkg::RDATA_RST;
		if (i_rd && (i_addr == exg_pkg::BIDIR_OFS)) begin
			st_nxt.rdata[exg_pkg::B_DCLR_LSB +: exg_pkg::BIDIR_N] = bdat_if.value;
			st_nxt.rdata[exg_pkg::B_DSET_LSB +: exg_pkg::BIDIR_N] = bdat_if.value;
			st_nxt.rdata[exg_pkg::B_ECLR_LSB +: exg_pkg::BIDIR_N] = ben_if.value;
			st_nxt.rdata[exg_pkg::B_ESET_LSB +: exg_pkg::BIDIR_N] = ben_if.value;
			st_nxt.rdata[exg_pkg::B_IN_LSB +: exg_pkg::BIDIR_N]   = st_r.bin_sync;
		end else if (i_rd && (i_addr == exg_pkg::XTRA_OFS)) begin
			st_nxt.rdata[exg_pkg::X_DCLR_LSB +: exg_pkg::XTRA_N] = odat_if.value;
			st_nxt.rdata[exg_pkg::X_DSET_LSB +: exg_pkg::XTRA_N] = odat_if.value;
			st_nxt.rdata[exg_pkg::X_ECLR_LSB +: exg_pkg::XTRA_N] = oen_if.value;
			st_nxt.rdata[exg_pkg::X_ESET_LSB +: exg_pkg::XTRA_N] = oen_if.value;
			st_nxt.rdata[exg_pkg::X_IN_LSB +: exg_pkg::XTRA_N]   = st_r.iin_sync;
		end
	end

	// State register; pins released at reset
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_r.bin_meta <= exg_pkg::BIDIR_RST;
			st_r.bin_sync <= exg_pkg::BIDIR_RST;
			st_r.iin_meta <= exg_pkg::XTRA_RST;
			st_r.iin_sync <= exg_pkg::XTRA_RST;
			st_r.rdata    <= exg_pkg::RDATA_RST;
			st_r.bout     <= exg_pkg::BIDIR_RST;
			st_r.boe_n    <= ~exg_pkg::BIDIR_RST;
			st_r.oout     <= exg_pkg::XTRA_RST;
			st_r.ooe_n    <= ~exg_pkg::XTRA_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flops
	assign o_rdata     = st_r.rdata;
	assign o_bpin      = st_r.bout;
	assign o_bpin_oe_n = st_r.boe_n;
	assign o_opin      = st_r.oout;
	assign o_opin_oe_n = st_r.ooe_n;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	chk_bdat_clear: assert property (
		(wr_bidir && i_wdata[5:3] == 3'h0)
		|=> ((bdat_if.value & $past(i_wdata[2:0])) == 3'h0)
	) else $error("bidir data bit not cleared");

	chk_bdat_set: assert property (
		wr_bidir |=> ((bdat_if.value & $past(i_wdata[5:3])) == $past(i_wdata[5:3]))
	) else $error("bidir data bit not set");

	chk_ben_clear: assert property (
		(wr_bidir && i_wdata[11:9] == 3'h0)
		|=> ((ben_if.value & $past(i_wdata[8:6])) == 3'h0)
	) else $error("bidir enable not cleared");

	// bidir enable set and untouched bits
	chk_ben_set: assert property (
		(wr_bidir && i_wdata[8:6] == 3'h0)
		|=> (ben_if.value == ($past(ben_if.value) | $past(i_wdata[11:9])))
	) else $error("bidir enable set wrong");

	chk_bin_read: assert property (
		(i_rd && i_addr == exg_pkg::BIDIR_OFS)
		|=> (o_rdata[14:12] == $past(st_r.bin_sync))
	) else $error("bidir input readback wrong");

	chk_odat_clear: assert property (
		(wr_xtra && i_wdata[7:4] == 4'h0)
		|=> (odat_if.value == ($past(odat_if.value) & ~$past(i_wdata[3:0])))
	) else $error("output data not cleared");

	chk_odat_set: assert property (
		wr_xtra |=> ((odat_if.value & $past(i_wdata[7:4])) == $past(i_wdata[7:4]))
	) else $error("output data not set");

	chk_oen_clear: assert property (
		(wr_xtra && i_wdata[15:12] == 4'h0)
		|=> ((oen_if.value & $past(i_wdata[11:8])) == 4'h0)
	) else $error("output enable not cleared");

	chk_oen_set: assert property (
		wr_xtra |=> ((oen_if.value & $past(i_wdata[15:12])) == $past(i_wdata[15:12]))
	) else $error("output enable not set");

	// input pin to read data path is three cycles deep
	chk_iin_read: assert property (
		(i_rd && i_addr == exg_pkg::XTRA_OFS)
		|=> (o_rdata[19:16] == $past(i_ipin, 3))
	) else $error("input pin readback wrong");

	// pin follows enable one cycle later
	chk_pin_drive: assert property (
		##1 (o_bpin_oe_n == ~$past(ben_if.value))
		&& (o_opin == ($past(odat_if.value) & $past(oen_if.value)))
	) else $error("pin drive does not follow enable");

	chk_view_match: assert property (
		(i_rd && i_addr == exg_pkg::XTRA_OFS)
		|=> (o_rdata[3:0] == o_rdata[7:4]) && (o_rdata[11:8] == o_rdata[15:12])
	) else $error("set and clear views differ");

	chk_rsvd_zero: assert property (
		(i_rd && i_addr == exg_pkg::BIDIR_OFS) |=> (o_rdata[31:15] == 17'h0_0000)
	) else $error("reserved bits not zero");

	chk_hold_idle: assert property (
		!i_wr |=> $stable(bdat_if.value) && $stable(oen_if.value)
	) else $error("control bits changed without write");

	// bidir data set leaves other bits
	chk_bdat_keep: assert property (
		(wr_bidir && i_wdata[2:0] == 3'h0)
		|=> (bdat_if.value == ($past(bdat_if.value) | $past(i_wdata[5:3])))
	) else $error("bidir data set touched other bits");

	// output enable set leaves other bits
	chk_oen_keep: assert property (
		(wr_xtra && i_wdata[11:8] == 4'h0)
		|=> (oen_if.value == ($past(oen_if.value) | $past(i_wdata[15:12])))
	) else $error("output enable set touched other bits");

	// bidir pin value follows data and enable
	chk_bpin_value: assert property (
		1'b1
		|=> (o_bpin == ($past(bdat_if.value) & $past(ben_if.value)))
	) else $error("bidir pin value wrong");

	// output pin enable follows stored enable
	chk_opin_oe: assert property (
		1'b1
		|=> (o_opin_oe_n == ~$past(oen_if.value))
	) else $error("output pin enable wrong");

	// bidir data views agree with store
	chk_bidir_view: assert property (
		(i_rd && i_addr == exg_pkg::BIDIR_OFS)
		|=> (o_rdata[5:0] == {2{$past(bdat_if.value)}})
	) else $error("bidir data views differ from store");

	// extra enable views agree with store
	chk_xtra_view: assert property (
		(i_rd && i_addr == exg_pkg::XTRA_OFS)
		|=> (o_rdata[15:8] == {2{$past(oen_if.value)}})
	) else $error("output enable views differ from store");

	// extra register reserved bits read zero
	chk_xtra_rsvd: assert property (
		(i_rd && i_addr == exg_pkg::XTRA_OFS)
		|=> (o_rdata[31:20] == 12'h000)
	) else $error("extra reserved bits not zero");

	chk_unmapped_zero: assert property (
		(i_rd && i_addr != exg_pkg::BIDIR_OFS && i_addr != exg_pkg::XTRA_OFS)
		|=> (o_rdata == exg_pkg::RDATA_RST)
	) else $error("unmapped read not zero");

	// read data stays zero without a read
	chk_rdata_idle: assert property (
		!i_rd
		|=> (o_rdata == exg_pkg::RDATA_RST)
	) else $error("read data not zero when idle");

endmodule : exg_gpio_top

// ==== exg_pkg.sv ====
// ****************************************************************
// Constants for the extended pin block
// ****************************************************************
package exg_pkg;

	// Register bus geometry
	localparam int          ADDR_W       = 12;
	localparam int          DATA_W       = 32;

	// Register byte addresses
	localparam logic [11:0] BIDIR_OFS    = 12'h300;
	localparam logic [11:0] XTRA_OFS     = 12'h304;

	// Pin counts
	localparam int          BIDIR_N      = 3;
	localparam int          XTRA_N       = 4;

	// Bidirectional control register field positions
	localparam int          B_DCLR_LSB   = 0;
	localparam int          B_DSET_LSB   = 3;
	localparam int          B_ECLR_LSB   = 6;
	localparam int          B_ESET_LSB   = 9;
	localparam int          B_IN_LSB     = 12;
	localparam int          B_RSVD_LSB   = 15;

	// Extra output/input register field positions
	localparam int          X_DCLR_LSB   = 0;
	localparam int          X_DSET_LSB   = 4;
	localparam int          X_ECLR_LSB   = 8;
	localparam int          X_ESET_LSB   = 12;
	localparam int          X_IN_LSB     = 16;
	localparam int          X_RSVD_LSB   = 20;

	// Values after reset
	localparam logic [2:0]  BIDIR_RST    = 3'h0;
	localparam logic [3:0]  XTRA_RST     = 4'h0;
	localparam logic [31:0] RDATA_RST    = 32'h0000_0000;

	// Depth of the input synchronisers, in cycles
	localparam int          SYNC_CYCLES  = 2;

endpackage : exg_pkg

// ==== exg_sc_if.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Set/clear strobes and stored value of one control vector
// ****************************************************************
interface exg_sc_if #(
	parameter int W = 3
);
	logic [W-1:0] set_mask;
	logic [W-1:0] clr_mask;
	logic [W-1:0] value;

	modport ctl  (output set_mask, output clr_mask, input value);
	modport bank (input set_mask, input clr_mask, output value);
endinterface : exg_sc_if

// ==== exg_sc_bank.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Vector of write-one-to-set / write-one-to-clear bits
// ****************************************************************
module exg_sc_bank #(
	parameter int         W   = 3,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	exg_sc_if.bank    sc
);

	typedef struct packed {
		logic [W-1:0] value;
	} exg_bank_state_type;

	exg_bank_state_type st_r;
	exg_bank_state_type st_nxt;

	// Clear first, then set: a set in the same write wins
	always_comb begin
		st_nxt       = st_r;
		st_nxt.value = (st_r.value & ~sc.clr_mask) | sc.set_mask;
	end

	// State register
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_r.value <= RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sc.value = st_r.value;

endmodule : exg_sc_bank

// ==== exg_pin_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Board-side levels on the block's pins
// ****************************************************************
module exg_pin_model (
	input  wire logic [2:0] i_bpin_out,
	input  wire logic [2:0] i_bpin_oe_n,
	input  wire logic [2:0] i_ext_b,
	input  wire logic [3:0] i_ext_i,
	output logic      [2:0] o_bpin_lvl,
	output logic      [3:0] o_ipin
);
	// Bidir wire: the block wins where it drives, the board elsewhere
	assign o_bpin_lvl = (i_bpin_out & ~i_bpin_oe_n) | (i_ext_b & i_bpin_oe_n);
	// Input-only pins follow the board
	assign o_ipin = i_ext_i;
endmodule : exg_pin_model

// ==== exg_gpio_top_tb.sv ====
`timescale 1ns/1ps
module exg_gpio_top_tb;
	logic        i_clk, i_sys_rst, i_wr, i_rd;
	logic [11:0] i_addr, a;
	logic [31:0] i_wdata, o_rdata, seed, w;
	logic [2:0]  o_bpin, o_bpin_oe_n, pin_b, ext_b, bd, be;
	logic [3:0]  o_opin, o_opin_oe_n, pin_i, ext_i, od, oe;
	logic [11:0] adr [4] = '{12'h300, 12'h304, 12'h308, 12'h301};
	int          n_errors, n_tests;

	exg_gpio_top exg_gpio_top_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_bpin(pin_b),
		.o_bpin(o_bpin), .o_bpin_oe_n(o_bpin_oe_n), .o_opin(o_opin),
		.o_opin_oe_n(o_opin_oe_n), .i_ipin(pin_i));
	exg_pin_model exg_pin_model_i (.i_bpin_out(o_bpin), .i_bpin_oe_n(o_bpin_oe_n),
		.i_ext_b(ext_b), .i_ext_i(ext_i), .o_bpin_lvl(pin_b), .o_ipin(pin_i));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// Expected register image from the bench's own state
	function automatic logic [31:0] exp_rd(input logic [11:0] ad);
		if (ad == 12'h300)
			return {17'h00000, (bd & be) | (ext_b & ~be), be, be, bd, bd};
		if (ad == 12'h304)
			return {12'h000, ext_i, oe, oe, od, od};
		return 32'h0000_0000;
	endfunction : exp_rd

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic op(input logic wv, input logic rv, input logic [11:0] ad,
		input logic [31:0] d);
		@(posedge i_clk);
		i_wr    <= wv;
		i_rd    <= rv;
		i_addr  <= ad;
		i_wdata <= d;
	endtask : op

	// Write and mirror it; set wins over clear in one word
	task automatic wr(input logic [11:0] ad, input logic [31:0] d);
		op(1'b1, 1'b0, ad, d);
		if (ad == 12'h300) begin
			bd = (bd & ~d[2:0]) | d[5:3];
			be = (be & ~d[8:6]) | d[11:9];
		end else if (ad == 12'h304) begin
			od = (od & ~d[3:0]) | d[7:4];
			oe = (oe & ~d[11:8]) | d[15:12];
		end
	endtask : wr

	task automatic rd_chk(input logic [11:0] ad, input logic [31:0] m);
		op(1'b0, 1'b1, ad, 32'h0000_0000);
		op(1'b0, 1'b0, ad, 32'h0000_0000);
		#1;
		check(o_rdata & m, exp_rd(ad) & m);
		@(posedge i_clk);
		#1;
		check(o_rdata, 32'h0000_0000);
	endtask : rd_chk

	task automatic pins_chk();
		check({18'h00000, o_bpin, o_bpin_oe_n, o_opin, o_opin_oe_n},
			{18'h00000, bd & be, ~be, od & oe, ~oe});
	endtask : pins_chk

	task automatic settle_chk();
		// Drop any strobe left by a write, then let pins settle
		op(1'b0, 1'b0, 12'h000, 32'h0000_0000);
		repeat (4) @(posedge i_clk);
		rd_chk(12'h300, 32'hFFFF_FFFF);
		rd_chk(12'h304, 32'hFFFF_FFFF);
		pins_chk();
	endtask : settle_chk

	task automatic tally_and_finish();
		if (n_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		seed = 32'h0001_2A10;
		{i_sys_rst, i_wr, i_rd, i_addr, i_wdata} = {1'b1, 46'h0};
		{ext_b, ext_i, bd, be, od, oe} = 21'h0;
		n_errors = 0;
		n_tests = 0;
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		settle_chk();
		// Corners: all ones, single clears, unmapped places
		wr(12'h300, 32'hFFFF_FFFF);
		wr(12'h304, 32'hFFFF_FFFF);
		settle_chk();
		wr(12'h300, 32'h0000_0041);
		wr(12'h304, 32'h0000_0108);
		wr(12'h308, 32'hFFFF_FFFF);
		wr(12'h302, 32'h0000_0000);
		settle_chk();
		rd_chk(12'h308, 32'hFFFF_FFFF);
		rd_chk(12'h2FC, 32'hFFFF_FFFF);
		// Random writes, each read back with no gap
		repeat (300) begin
			w = rnd();
			a = adr[w[1:0]];
			ext_b <= w[6:4];
			ext_i <= w[11:8];
			wr(a, rnd());
			rd_chk(a, (a == 12'h304) ? 32'hFFF0_FFFF : 32'hFFFF_8FFF);
			settle_chk();
		end
		// Mid-run reset clears every data and enable bit
		@(posedge i_clk);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		{bd, be, od, oe} = 14'h0000;
		settle_chk();
		tally_and_finish();
	end

	// Hang guard
	initial begin
		#400000;
		n_errors++;
		tally_and_finish();
	end
endmodule : exg_gpio_top_tb
